//--- common/spi_defines.vh
/*
  Register offsets, field positions, reset values and widths of the serial
  peripheral unit. Assumes inclusion by bare name from the design files.
*/
`ifndef SPI_DEFINES_VH
`define SPI_DEFINES_VH

// Byte addresses of the registers on the AHB-Lite bus.
`define ADDR_CTRL 5'h00
`define ADDR_STATUS 5'h04
`define ADDR_MASK 5'h08
`define ADDR_DATA 5'h0C
`define ADDR_DIV 5'h10

// Fields of the port control register.
`define CTRL_EN_BIT 0
`define CTRL_MS_BIT 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3

// Select mode encodings.
`define MODE_3WIRE 2'h0
`define MODE_4WIRE_IN 2'h1

// Status bits; bits 0-3 are sticky and shared with the mask register, bits 8-10 are live.
`define ST_DONE_BIT 0
`define ST_WCOL_BIT 1
`define ST_MODE_FAULT_FLAG_BIT 2
`define ST_OVR_BIT 3
`define ST_WIDTH 4
`define ST_BUSY_BIT 8
`define ST_TXFULL_BIT 9
`define ST_RXFULL_BIT 10

// Reset values and the last bit index of a byte.
`define CTRL_MODE_RST 2'h1
`define DIV_RST 8'h04
`define BYTE_LAST 3'h7

`endif

//--- verilog/sync2.v
/*
  Two-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a slowly changing level from outside the mclk domain.
*/
`default_nettype none

module sync2 #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- verilog/clk_div.v
/*
  Enable divider: a one-cycle tick every div_val cycles of mclk while run is high.
  Assumes div_val of zero is treated as one.
*/
`default_nettype none

module clk_div #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire run,
  input wire [WIDTH-1:0] div_val,
  output reg tick
);

  reg [WIDTH-1:0] cnt_r;

  // Counts up to one below the divide value and restarts whenever run drops.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (cnt_r + 1'b1 >= div_val) begin
      cnt_r <= {WIDTH{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- verilog/spi_port.v
/*
  Serial peripheral unit: SPI master or slave with three select modes,
  AHB-Lite register slave and one level interrupt.
  Assumes pins are sampled on mclk, clock mode is idle low with data
  sampled on the rising serial clock edge, and hready equals hreadyout.
*/
`include "spi_defines.vh"
`default_nettype none

// What this block does
// - Bytes shift most significant bit first.
// - Master drives master-out from shift top.
// - Master makes clock, drives out, samples in.
// - Slave takes clock, master-out in, drives in-line.
// - Float slave output when disabled or deselected.
// - Three-wire slave always drives its output.
// - Deselected four-wire slave ignores serial clock.
// - Mode 00: three-wire, slave always selected.
// - Mode 01: select input, low selects.
// - Mode 01 master: select fall aborts master.
// - Mode 1x: select output equals low bit.
// - Select pin routed except in mode 00.
// - Fault clears enables and sets fault flag.
// - Four-wire slave: select fall clears counter.
// - Three-wire slave counter clears by re-enable.
module spi_port #(
  parameter DIV_W = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  output reg irq,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe_n,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe_n,
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe_n,
  input wire nss_in,
  output reg nss_out,
  output reg nss_oe_n,
  output reg nss_routed
);

  wire [3:0] pin_s;
  wire sck_s;
  wire mosi_s;
  wire miso_s;
  wire nss_s;
  wire tick;
  reg sck_d_r;
  reg nss_d_r;
  reg ctrl_en_r;
  reg ctrl_ms_r;
  reg [1:0] mode_r;
  reg [DIV_W-1:0] div_r;
  reg [`ST_WIDTH-1:0] status_r;
  reg [`ST_WIDTH-1:0] mask_r;
  reg [`ST_WIDTH-1:0] status_nxt;
  reg [7:0] tx_r;
  reg tx_full_r;
  reg [7:0] shift_r;
  reg shift_empty_r;
  reg [7:0] rx_r;
  reg rx_full_r;
  reg [2:0] cnt_r;
  reg bit_r;
  reg busy_r;
  reg last_r;
  reg sck_r;
  reg ap_wr_r;
  reg [4:0] ap_addr_r;
  reg [31:0] rd_nxt;

  // Pin levels cross into mclk through two flops before any use.
  sync2 #(
    .WIDTH(4),
    .RST_VAL(4'h8)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({nss_in, miso_in, mosi_in, sck_in}),
    .q(pin_s)
  );

  assign sck_s = pin_s[0];
  assign mosi_s = pin_s[1];
  assign miso_s = pin_s[2];
  assign nss_s = pin_s[3];

  // Master serial clock half-period ticks.
  clk_div #(
    .WIDTH(DIV_W)
  ) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(busy_r),
    .div_val(div_r),
    .tick(tick)
  );

  // Role and select decode.
  wire is_master = ctrl_en_r & ctrl_ms_r;
  wire mode_in = (mode_r == `MODE_4WIRE_IN);
  wire mode_3w = (mode_r == `MODE_3WIRE);
  wire slave_sel = mode_3w | mode_r[1] | (mode_in & ~nss_s);
  wire slave_act = ctrl_en_r & ~ctrl_ms_r & slave_sel;
  wire nss_fall = nss_d_r & ~nss_s;

  // Edge events of the serial clock, from the pin as slave or own clock as master.
  wire s_rise = slave_act & sck_s & ~sck_d_r;
  wire s_fall = slave_act & ~sck_s & sck_d_r;
  wire m_rise = is_master & busy_r & tick & ~sck_r;
  wire m_fall = is_master & busy_r & tick & sck_r;
  wire rise_ev = m_rise | s_rise;
  wire fall_ev = m_fall | s_fall;
  wire din = is_master ? miso_s : mosi_s;
  wire byte_done = rise_ev & (cnt_r == `BYTE_LAST);

  // A select fall seen by a master in mode 01 means another master took the bus.
  wire mfault = is_master & mode_in & nss_fall;

  // Bus strobes: register writes in the data phase, data-register read in the address phase.
  wire wr_ctrl = ap_wr_r & (ap_addr_r == `ADDR_CTRL);
  wire wr_status = ap_wr_r & (ap_addr_r == `ADDR_STATUS);
  wire wr_mask = ap_wr_r & (ap_addr_r == `ADDR_MASK);
  wire wr_data = ap_wr_r & (ap_addr_r == `ADDR_DATA);
  wire wr_div = ap_wr_r & (ap_addr_r == `ADDR_DIV);
  wire ap_take = hsel & hready & htrans[1];
  wire rd_data = ap_take & ~hwrite & (haddr[4:0] == `ADDR_DATA);
  wire load_shift = tx_full_r & shift_empty_r & ~busy_r & ctrl_en_r;

  // Previous synchronised levels for edge detection.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'b0;
      nss_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      nss_d_r <= nss_s;
    end
  end

  // Address phase capture; every transfer completes with no wait state.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 5'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ap_wr_r <= ap_take & hwrite & (hsize == 3'h2);
      ap_addr_r <= haddr[4:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (haddr[4:0])
      `ADDR_CTRL: begin
        rd_nxt[`CTRL_EN_BIT] = ctrl_en_r;
        rd_nxt[`CTRL_MS_BIT] = ctrl_ms_r;
        rd_nxt[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_r;
      end
      `ADDR_STATUS: begin
        rd_nxt[`ST_WIDTH-1:0] = status_r;
        rd_nxt[`ST_BUSY_BIT] = busy_r | ~shift_empty_r;
        rd_nxt[`ST_TXFULL_BIT] = tx_full_r;
        rd_nxt[`ST_RXFULL_BIT] = rx_full_r;
      end
      `ADDR_MASK: rd_nxt[`ST_WIDTH-1:0] = mask_r;
      `ADDR_DATA: rd_nxt[7:0] = rx_r;
      `ADDR_DIV: rd_nxt[DIV_W-1:0] = div_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase so it stands in the data phase.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take & ~hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // Control, mask and divider registers; a mode fault overrides a software write of the enable and master bits in the same cycle.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_r <= 1'b0;
      ctrl_ms_r <= 1'b0;
      mode_r <= `CTRL_MODE_RST;
      div_r <= `DIV_RST;
      mask_r <= {`ST_WIDTH{1'b0}};
    end else begin
      if (mfault) begin
        ctrl_en_r <= 1'b0;
        ctrl_ms_r <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_en_r <= hwdata[`CTRL_EN_BIT];
        ctrl_ms_r <= hwdata[`CTRL_MS_BIT];
      end
      if (wr_ctrl) begin
        mode_r <= hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
      end
      if (wr_mask) begin
        mask_r <= hwdata[`ST_WIDTH-1:0];
      end
      if (wr_div) begin
        div_r <= hwdata[DIV_W-1:0];
      end
    end
  end

  // Sticky status: hardware set wins over a write-one clear.
  always @* begin
    status_nxt = status_r & ~(wr_status ? hwdata[`ST_WIDTH-1:0] : {`ST_WIDTH{1'b0}});
    if (byte_done) begin
      status_nxt[`ST_DONE_BIT] = 1'b1;
    end
    if (wr_data & tx_full_r) begin
      status_nxt[`ST_WCOL_BIT] = 1'b1;
    end
    if (mfault) begin
      status_nxt[`ST_MODE_FAULT_FLAG_BIT] = 1'b1;
    end
    if (byte_done & rx_full_r & ~is_master) begin
      status_nxt[`ST_OVR_BIT] = 1'b1;
    end
  end

  // Status register and the level interrupt from it.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= {`ST_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
    end
  end

  // Transmit buffer; a write while full is dropped and flagged.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (!ctrl_en_r) begin
      tx_full_r <= 1'b0;
    end else if (wr_data & ~tx_full_r) begin
      tx_r <= hwdata[7:0];
      tx_full_r <= 1'b1;
    end else if (load_shift) begin
      tx_full_r <= 1'b0;
    end
  end

  // Receive buffer; an unread byte is kept and the newer one lost as slave.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= 8'h00;
      rx_full_r <= 1'b0;
    end else if (byte_done & (~rx_full_r | is_master)) begin
      rx_r <= {shift_r[6:0], din};
      rx_full_r <= 1'b1;
    end else if (rd_data) begin
      rx_full_r <= 1'b0;
    end
  end

  // Shift engine shared by both roles: sample on rise, shift on fall.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 8'h00;
      shift_empty_r <= 1'b1;
      cnt_r <= 3'h0;
      bit_r <= 1'b0;
      busy_r <= 1'b0;
      last_r <= 1'b0;
      sck_r <= 1'b0;
    end else if (!ctrl_en_r) begin
      cnt_r <= 3'h0;
      shift_empty_r <= 1'b1;
      busy_r <= 1'b0;
      last_r <= 1'b0;
      sck_r <= 1'b0;
    end else if (~ctrl_ms_r & mode_in & nss_fall) begin
      cnt_r <= 3'h0;
      last_r <= 1'b0;
    end else begin
      if (load_shift) begin
        shift_r <= tx_r;
        shift_empty_r <= 1'b0;
        busy_r <= ctrl_ms_r;
      end
      if (m_rise | m_fall) begin
        sck_r <= ~sck_r;
      end
      if (rise_ev) begin
        bit_r <= din;
        cnt_r <= cnt_r + 3'h1;
        if (byte_done) begin
          shift_empty_r <= 1'b1;
          last_r <= 1'b1;
        end
      end
      if (fall_ev) begin
        if (!last_r) begin
          shift_r <= {shift_r[6:0], bit_r};
        end
        if (last_r) begin
          last_r <= 1'b0;
          busy_r <= 1'b0;
        end
      end
    end
  end

  // Master pins: clock and master-out driven, master-in read as input.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_out <= 1'b0;
      sck_oe_n <= 1'b1;
      mosi_out <= 1'b0;
      mosi_oe_n <= 1'b1;
    end else begin
      sck_out <= sck_r;
      sck_oe_n <= ~is_master;
      mosi_out <= shift_r[7];
      mosi_oe_n <= ~is_master;
    end
  end

  // Slave output: driven from the shift top unless disabled or deselected.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_out <= shift_r[7];
      miso_oe_n <= ~(ctrl_en_r & ~ctrl_ms_r & slave_sel);
    end
  end

  // Select pin: output in mode 1x carrying the low mode bit, routed unless 3-wire.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nss_out <= 1'b1;
      nss_oe_n <= 1'b1;
      nss_routed <= 1'b0;
    end else begin
      nss_out <= mode_r[0];
      nss_oe_n <= ~mode_r[1];
      nss_routed <= ~mode_3w;
    end
  end

endmodule
`default_nettype wire

//--- dv/spi_port_monitor.sv
/* Pin-level assertions for spi_port.
   Assumes it is bound to spi_port and sees only its ports. */
`default_nettype none
module spi_port_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic mosi_out,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic nss_in,
  input wire logic nss_oe_n,
  input wire logic nss_routed
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Drive roles of the pins follow master or slave role.
  a_master_pins: assert property (mosi_oe_n == sck_oe_n)
    else $error("clock and data enables differ");
  a_slave_pins: assert property (!miso_oe_n |-> mosi_oe_n && sck_oe_n)
    else $error("slave drives master pins");
  a_deselect_float: assert property ((nss_routed && nss_oe_n && nss_in) [*6] |-> miso_oe_n)
    else $error("deselected slave drives");
  a_slave_select: assert property (!miso_oe_n && nss_routed |-> nss_oe_n)
    else $error("slave output with select driven");
  a_select_routed: assert property (!nss_oe_n |-> nss_routed)
    else $error("select driven but unrouted");
  // Data and select timing relative to clock and synchroniser.
  a_mosi_hold: assert property (!mosi_oe_n && sck_out && $past(sck_out) |-> $stable(mosi_out))
    else $error("data moved while clock high");
  a_sync_fall: assert property ($fell(nss_in) |=> $stable(miso_oe_n) [*2])
    else $error("select not synchronised");
  a_fault_release: assert property (!mosi_oe_n && nss_oe_n && nss_routed && $fell(nss_in) |=>
    !mosi_oe_n ##[1:6] mosi_oe_n) else $error("master kept after select fall");
endmodule
`default_nettype wire

//--- dv/spi_far_end.sv
/* Far side of the link: outside master or slave, mode 0, MSB first.
   Assumes the bench resolves each pin from both parties' enables. */
`default_nettype none
module spi_far_end (
  input wire logic sck_line,
  input wire logic mosi_line,
  input wire logic miso_line,
  output logic sck_drv,
  output logic mosi_drv,
  output logic miso_drv,
  output logic nss_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] reply = 8'h00;
  logic [7:0] got;
  initial {sck_drv, mosi_drv, miso_drv, nss_drv} = 4'h5;
  // As a slave it samples on the rise and shifts its reply on the fall.
  always @(posedge sck_line) got <= {got[6:0], mosi_line};
  always @(negedge sck_line) begin
    reply = {reply[6:0], ~reply[7]};
    miso_drv = reply[7];
  end
  // As a master it sends n bits at a 200 ns clock; the clock stands low outside frames.
  // The select is dropped by a non-blocking write so the synchroniser never races it.
  // A trailing gap keeps the select high long enough for the next frame to show a fresh fall.
  task automatic xfer(input logic [7:0] tx, input int n, input logic sel, output logic [7:0] rx);
    nss_drv <= !sel;
    #57;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_drv = tx[i];
      #100 sck_drv = 1'h1;
      rx = {rx[6:0], miso_line};
      #100 sck_drv = 1'h0;
    end
    #60 nss_drv = 1'h1;
    mosi_drv = ~mosi_drv;
    #200;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
/* Bench of spi_port: AHB-Lite tasks, one task per scenario.
   Assumes the design, monitor and spi_far_end are compiled first. */
`include "spi_defines.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic nss_out, nss_oe_n, nss_routed, f_sck, f_mosi, f_miso, f_nss;
  logic [7:0] rx;
  int bad_count = 0;
  int tests_run = 0;
  // Each pin carries whichever party has its enable on.
  wire sck_l = sck_oe_n ? f_sck : sck_out;
  wire mosi_l = mosi_oe_n ? f_mosi : mosi_out;
  wire miso_l = miso_oe_n ? f_miso : miso_out;
  wire nss_l = nss_oe_n ? f_nss : nss_out;
  spi_port dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .irq(irq), .sck_in(sck_l), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_l), .mosi_out(mosi_out),
    .mosi_oe_n(mosi_oe_n), .miso_in(miso_l), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .nss_in(nss_l),
    .nss_out(nss_out), .nss_oe_n(nss_oe_n), .nss_routed(nss_routed));
  spi_far_end far (.sck_line(sck_l), .mosi_line(mosi_l), .miso_line(miso_l), .sck_drv(f_sck),
    .mosi_drv(f_mosi), .miso_drv(f_miso), .nss_drv(f_nss));
  // Clock of 25 ns period.
  always #12.5 mclk = ~mclk;
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask
  // One single word transfer; read data is taken at the data phase edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h000_0000, a};
    do @(posedge mclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk_bit("hresp", 1'h0, hresp);
  endtask
  task automatic t_master;
    bus(0, 5'h1C, 32'h0000_0000);
    chk_word("unmapped", 32'h0000_0000, rd);
    bus(0, `ADDR_CTRL, 32'h0000_0000);
    chk_word("ctrl reset", 32'h0000_0004, rd);
    bus(0, `ADDR_DIV, 32'h0000_0000);
    chk_word("div reset", {24'h00_0000, `DIV_RST}, rd);
    far.reply = 8'hA5;
    far.miso_drv = 1'h1;
    bus(1, `ADDR_CTRL, 32'h0000_0003);
    bus(1, `ADDR_DATA, 32'h0000_003C);
    for (int i = 0; i < 60 && rd[0] !== 1'h1; i++) bus(0, `ADDR_STATUS, 32'h0000_0000);
    chk_word("sent", 32'h0000_003C, {24'h00_0000, far.got});
    bus(0, `ADDR_DATA, 32'h0000_0000);
    chk_word("recv", 32'h0000_00A5, rd);
    chk_bit("unrouted", 1'h0, nss_routed);
    for (int m = 2; m < 4; m++) begin
      bus(1, `ADDR_CTRL, {28'h000_0000, m[1:0], 2'h3});
      repeat (2) @(negedge mclk);
      chk_bit("nss drive", 1'h0, nss_oe_n);
      chk_bit("nss level", m[0], nss_out);
    end
    $display("test master done");
  endtask
  task automatic t_slave4;
    bus(1, `ADDR_CTRL, 32'h0000_0005);
    bus(1, `ADDR_STATUS, 32'h0000_000F);
    bus(1, `ADDR_DATA, 32'h0000_0096);
    far.xfer(8'hFF, 8, 1'h0, rx);
    bus(0, `ADDR_STATUS, 32'h0000_0000);
    chk_bit("ignored", 1'h0, rd[`ST_DONE_BIT]);
    far.xfer(8'h5A, 8, 1'h1, rx);
    chk_word("slave out", 32'h0000_0096, {24'h00_0000, rx});
    chk_bit("masked", 1'h0, irq);
    bus(1, `ADDR_MASK, 32'h0000_0001);
    repeat (2) @(negedge mclk);
    chk_bit("irq", 1'h1, irq);
    bus(0, `ADDR_DATA, 32'h0000_0000);
    chk_word("slave in", 32'h0000_005A, rd);
    far.xfer(8'hE0, 3, 1'h1, rx);
    far.xfer(8'hC3, 8, 1'h1, rx);
    bus(0, `ADDR_DATA, 32'h0000_0000);
    chk_word("recount", 32'h0000_00C3, rd);
    bus(1, `ADDR_STATUS, 32'h0000_000F);
    repeat (2) @(negedge mclk);
    chk_bit("irq clear", 1'h0, irq);
    $display("test slave4 done");
  endtask
  task automatic t_slave3;
    bus(1, `ADDR_CTRL, 32'h0000_0001);
    far.xfer(8'hE0, 3, 1'h0, rx);
    chk_bit("3w drive", 1'h0, miso_oe_n);
    bus(1, `ADDR_CTRL, 32'h0000_0000);
    repeat (2) @(negedge mclk);
    chk_bit("off float", 1'h1, miso_oe_n);
    bus(1, `ADDR_CTRL, 32'h0000_0001);
    far.xfer(8'h81, 8, 1'h0, rx);
    bus(0, `ADDR_DATA, 32'h0000_0000);
    chk_word("3w recv", 32'h0000_0081, rd);
    $display("test slave3 done");
  endtask
  task automatic t_fault;
    bus(1, `ADDR_STATUS, 32'h0000_000F);
    bus(1, `ADDR_CTRL, 32'h0000_0007);
    repeat (2) @(negedge mclk);
    chk_bit("master on", 1'h0, mosi_oe_n);
    far.nss_drv = 1'h0;
    repeat (8) @(negedge mclk);
    far.nss_drv = 1'h1;
    chk_bit("released", 1'h1, mosi_oe_n);
    bus(0, `ADDR_CTRL, 32'h0000_0000);
    chk_word("ctrl fault", 32'h0000_0004, rd);
    bus(0, `ADDR_STATUS, 32'h0000_0000);
    chk_bit("fault flag", 1'h1, rd[`ST_MODE_FAULT_FLAG_BIT]);
    $display("test fault done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    t_master();
    t_slave4();
    t_slave3();
    t_fault();
    close_out();
  end
  // Cuts a hang short well after the expected run time.
  initial begin
    #100us;
    bad_count++;
    close_out();
  end
endmodule
bind spi_port spi_port_monitor mon (.mclk(mclk), .rst_n(rst_n), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
  .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .nss_in(nss_in), .nss_oe_n(nss_oe_n),
  .nss_routed(nss_routed));
`default_nettype wire
